// ---- inc/ifr_consts.svh ----
/*
 * Offsets, field positions, reset values and counts for the pending-flag
 * and measurement-result register bank. Included by the RTL files.
 */
`ifndef IFR_CONSTS_SVH
`define IFR_CONSTS_SVH

// ============================================================
// register offsets
`define IFR_OFF_PENDING     8'h21
`define IFR_OFF_VIS_LO      8'h22
`define IFR_OFF_VIS_HI      8'h23
`define IFR_OFF_IR_LO       8'h24
`define IFR_OFF_IR_HI       8'h25
`define IFR_OFF_PX1_LO      8'h26
`define IFR_OFF_PX1_HI      8'h27
`define IFR_OFF_PX2_LO      8'h28

// ============================================================
// pending-flag field positions
`define IFR_BIT_CMD         5
`define IFR_BIT_PX3         4
`define IFR_BIT_PX2         3
`define IFR_BIT_PX1         2
`define IFR_BIT_ALS_HI      1
`define IFR_BIT_ALS_LO      0
`define IFR_PENDING_MASK    8'h3F

// ============================================================
// reset values and encodings
`define IFR_RESULT_RESET    8'h00
`define IFR_PENDING_RESET   8'h00
`define IFR_ENABLE_RESET    8'h00
`define IFR_MODE_HOLD       2'h3
`define IFR_NUM_RESULTS     4

`endif

// ---- inc/ifr_pkg.sv ----
/*
 * Types for the pending-flag and result register bank.
 * Assumes ifr_consts.svh is reachable on the include path.
 */
package ifr_pkg;
	typedef logic [7:0]  ifr_byte_t;
	typedef logic [15:0] ifr_word_t;
	typedef enum logic [1:0] {
		IFR_CAP_IDLE,
		IFR_CAP_FLAG
	} ifr_cap_state_t;
endpackage : ifr_pkg

// ---- rtl/ifr_result_word.sv ----
/*
 * One 16-bit measurement result held as a low/high byte pair.
 * Assumes the sequencer's load and the host's byte writes arrive on clk.
 */
`timescale 1ns/100ps
`include "ifr_consts.svh"

module ifr_result_word
	import ifr_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      resetn,
	input  wire logic      load,
	input  wire ifr_word_t load_value,
	input  wire logic      wr_lo,
	input  wire logic      wr_hi,
	input  wire ifr_byte_t wr_data,
	output      ifr_word_t value
);
	ifr_word_t word_q;
	ifr_word_t word_d;

	// ============================================================
	// next value: measurement load wins over a host byte write
	always_comb begin
		word_d = word_q;
		if (wr_lo) begin
			word_d[7:0] = wr_data;
		end
		if (wr_hi) begin
			word_d[15:8] = wr_data;
		end
		if (load) begin
			word_d = load_value; // RL12
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			word_q <= {`IFR_RESULT_RESET, `IFR_RESULT_RESET}; // RL10
		end else begin
			word_q <= word_d;
		end
	end

	assign value = word_q;
endmodule : ifr_result_word

// ---- rtl/ifr_flag_bank.sv ----
/*
 * Pending-flag register, alert pin and measurement-result byte registers
 * of a light and proximity sensor. Host access arrives as a decoded byte
 * port (address, write strobe, read data) from the serial slave; the
 * sequencer side delivers results, flag events and clear requests on clk.
 */
`timescale 1ns/100ps
`include "ifr_consts.svh"

// Overview of operation
// RL1: pending flags hold command-done at bit 5, proximity three, two, one at bits 4..2, ambient light at 1:0, 7:6 reserved.
// RL2: the alert pin is high while any pending flag is set together with its enable bit.
// RL3: with clear policy 0 a flag stays set until the host writes one to its bit.
// RL4: with clear policy 1 the sequencer's clear empties all flags except proximity sources in hold mode 11.
// RL5: the visible-light result is shown low byte at 0x22, high byte at 0x23.
// RL6: the infrared-light result is shown low byte at 0x24, high byte at 0x25.
// RL7: the first proximity result is shown low byte at 0x26, high byte at 0x27.
// RL8: the low byte of the second proximity result is shown at 0x28.
// RL9: the host reads each result byte after the alert and before the next measurement overwrites it.
// RL10: every result byte resets to all zeros.
// RL11: any nonzero ambient-light flag field counts as pending for the alert.
// RL12: both bytes of a result are updated before its pending flag is set.
module ifr_flag_bank
	import ifr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [7:0] host_addr,
	input  wire logic       host_wr,
	input  wire ifr_byte_t  host_wdata,
	input  wire logic       host_rd,
	output      ifr_byte_t  host_rdata,
	input  wire ifr_byte_t  irq_enable,
	input  wire logic       clear_policy,
	input  wire logic [1:0] proximity_alert_mode_1,
	input  wire logic [1:0] proximity_alert_mode_2,
	input  wire logic [1:0] proximity_alert_mode_3,
	input  wire logic       auto_clear,
	input  wire logic [3:0] result_load,
	input  wire ifr_word_t  result_value,
	input  wire ifr_byte_t  flag_event,
	output      logic       alert
);
	// ============================================================
	// results: index 0 visible, 1 infrared, 2 proximity one, 3 proximity two
	ifr_word_t      word [`IFR_NUM_RESULTS];
	ifr_byte_t      pend_q;
	ifr_byte_t      pend_d;
	ifr_byte_t      flag_hold_q;
	ifr_byte_t      flag_hold_d;
	ifr_cap_state_t cap_q;
	ifr_cap_state_t cap_d;
	ifr_byte_t      rdata_q;
	ifr_byte_t      rdata_d;
	logic           alert_q;
	logic           alert_d;
	ifr_byte_t      keep_mask;
	ifr_byte_t      active;

	genvar g;
	generate
		for (g = 0; g < `IFR_NUM_RESULTS; g++) begin : g_res
			localparam logic [7:0] LO = `IFR_OFF_VIS_LO + 8'(2 * g);
			ifr_result_word u_word (
				.clk        (clk),
				.resetn     (resetn),
				.load       (result_load[g]), // RL12
				.load_value (result_value),
				.wr_lo      (host_wr && host_addr == LO),
				.wr_hi      (host_wr && host_addr == LO + 8'h01),
				.wr_data    (host_wdata),
				.value      (word[g])
			);
		end
	endgenerate

	// ============================================================
	// flag capture: events are delayed one cycle so the result word
	// is already stored when its flag appears
	always_comb begin
		flag_hold_d = flag_event & `IFR_PENDING_MASK;
		cap_d       = (flag_hold_d != 8'h00) ? IFR_CAP_FLAG : IFR_CAP_IDLE; // RL12
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			flag_hold_q <= `IFR_PENDING_RESET;
			cap_q       <= IFR_CAP_IDLE;
		end else begin
			flag_hold_q <= flag_hold_d;
			cap_q       <= cap_d;
		end
	end

	// ============================================================
	// pending flags
	always_comb begin
		keep_mask = 8'h00;
		keep_mask[`IFR_BIT_PX1] = (proximity_alert_mode_1 == `IFR_MODE_HOLD); // RL4
		keep_mask[`IFR_BIT_PX2] = (proximity_alert_mode_2 == `IFR_MODE_HOLD); // RL4
		keep_mask[`IFR_BIT_PX3] = (proximity_alert_mode_3 == `IFR_MODE_HOLD); // RL4
		pend_d = pend_q;
		if (host_wr && host_addr == `IFR_OFF_PENDING) begin
			pend_d = pend_d & ~host_wdata; // RL3
		end
		if (clear_policy && auto_clear) begin
			pend_d = pend_d & keep_mask; // RL4
		end
		if (cap_q == IFR_CAP_FLAG) begin
			// a new event beats a clear in the same cycle
			pend_d = pend_d | flag_hold_q;
		end
		pend_d = pend_d & `IFR_PENDING_MASK; // RL1
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pend_q <= `IFR_PENDING_RESET;
		end else begin
			pend_q <= pend_d;
		end
	end

	// ============================================================
	// alert pin, registered so it never glitches on the pin
	always_comb begin
		active  = pend_q & irq_enable & `IFR_PENDING_MASK; // RL2
		alert_d = (active[7:2] != 6'h00) || (active[`IFR_BIT_ALS_HI:`IFR_BIT_ALS_LO] != 2'h0); // RL11
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			alert_q <= 1'b0;
		end else begin
			alert_q <= alert_d;
		end
	end

	assign alert = alert_q; // RL2

	// ============================================================
	// read data, held until the next read; unmapped offsets read zero.
	// the host is relied on to fetch results between alert and the next
	// measurement, since a new load simply overwrites them (RL9)
	always_comb begin
		rdata_d = rdata_q;
		if (host_rd) begin
			unique case (host_addr)
				`IFR_OFF_PENDING: rdata_d = pend_q; // RL1
				`IFR_OFF_VIS_LO:  rdata_d = word[0][7:0]; // RL5
				`IFR_OFF_VIS_HI:  rdata_d = word[0][15:8]; // RL5
				`IFR_OFF_IR_LO:   rdata_d = word[1][7:0]; // RL6
				`IFR_OFF_IR_HI:   rdata_d = word[1][15:8]; // RL6
				`IFR_OFF_PX1_LO:  rdata_d = word[2][7:0]; // RL7
				`IFR_OFF_PX1_HI:  rdata_d = word[2][15:8]; // RL7
				`IFR_OFF_PX2_LO:  rdata_d = word[3][7:0]; // RL8
				default:          rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign host_rdata = rdata_q;
endmodule : ifr_flag_bank

// ---- test/ifr_bank_chk.sv ----
/* port checker for the flag bank.
   assumes enables and clear policy move only between transfers. */
`timescale 1ns/100ps
module ifr_bank_chk
	import ifr_pkg::*;
(
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic [7:0] host_addr,
	input wire logic       host_wr,
	input wire ifr_byte_t  host_wdata,
	input wire logic       host_rd,
	input wire ifr_byte_t  host_rdata,
	input wire ifr_byte_t  irq_enable,
	input wire logic       clear_policy,
	input wire logic       auto_clear,
	input wire ifr_byte_t  flag_event,
	input wire logic       alert
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// ====================
	// alert and flags
	property p_cmd; flag_event[5] && irq_enable[5] ##1 irq_enable[5] [*2] |=> alert; endproperty
	a_cmd: assert property (p_cmd) else $error("alert late");
	property p_als; flag_event[0] && irq_enable[0] ##1 irq_enable[0] [*2] |=> alert; endproperty
	a_als: assert property (p_als) else $error("light flag no alert");
	property p_off; (irq_enable == 8'h00) [*2] |-> !alert; endproperty
	a_off: assert property (p_off) else $error("alert unmasked");
	// a clear racing an event loses, so the cycle before must be quiet
	property p_w1c; !(|flag_event) ##1 (host_wr && host_addr == 8'h21 && host_wdata == 8'h3F) |=> ##1 !alert; endproperty
	a_w1c: assert property (p_w1c) else $error("write one kept alert");
	property p_keep; !host_wr && !auto_clear ##1 alert && $stable(irq_enable) |=> alert; endproperty
	a_keep: assert property (p_keep) else $error("flag lost");
	// an event sampled with the clear itself sets its flag again one cycle later, so it must be quiet too
	property p_auto; !(|flag_event) && irq_enable == 8'h20 ##1 (clear_policy && auto_clear && irq_enable == 8'h20
		&& !(|flag_event))
		##1 irq_enable == 8'h20 |=> !alert; endproperty
	a_auto: assert property (p_auto) else $error("auto clear missed");
	property p_gap; host_rd && host_addr == 8'h29 |=> host_rdata == 8'h00; endproperty
	a_gap: assert property (p_gap) else $error("high byte visible");
	property p_rsv; host_rd && host_addr == 8'h21 |=> host_rdata[7:6] == 2'b00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	c_rd: cover property (host_rd && host_addr == 8'h21);
	c_auto: cover property (clear_policy && auto_clear);
	c_alert: cover property ($rose(alert));
endmodule : ifr_bank_chk

// ---- test/ifr_host_model.sv ----
/* host on the byte port: one-cycle read or write strobes.
   assumes one caller at a time. */
`timescale 1ns/100ps
module ifr_host_model
	import ifr_pkg::*;
(
	input  wire logic       clk,
	output      logic [7:0] host_addr,
	output      logic       host_wr,
	output      ifr_byte_t  host_wdata,
	output      logic       host_rd,
	input  wire ifr_byte_t  host_rdata
);
	// ====================
	// transfers
	initial begin
		{host_addr, host_wdata, host_wr, host_rd} = 18'h00000;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input ifr_byte_t d, output ifr_byte_t q);
		@(posedge clk) #1;
		{host_addr, host_wdata, host_wr, host_rd} = {a, d, w, ~w};
		@(posedge clk) #1;
		// released lines flip so a stale value never looks valid
		{host_addr, host_wdata, host_wr, host_rd} = {~a, ~d, 2'b00};
		q = host_rdata;
	endtask : xfer
endmodule : ifr_host_model

// ---- test/irq_flags_and_result_regs_tb_top.sv ----
/* bench for the flag bank: host model on the byte port, sequencer pulses here.
   assumes one 10 MHz clock and synchronous active-low reset. */
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
	$display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
module irq_flags_and_result_regs_tb_top;
	import ifr_pkg::*;
	logic       clk, resetn, host_wr, host_rd, clear_policy, auto_clear, alert;
	logic [7:0] host_addr;
	logic [1:0] proximity_alert_mode_1, proximity_alert_mode_2, proximity_alert_mode_3;
	logic [3:0] result_load;
	ifr_byte_t  host_wdata, host_rdata, irq_enable, flag_event;
	ifr_word_t  result_value;
	int         errors, total_checks;
	ifr_flag_bank DUT (.*);
	ifr_host_model u_host (.*);
	// ====================
	// tasks
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic acc(input logic w, input logic [7:0] a, input ifr_byte_t d);
		ifr_byte_t q;
		u_host.xfer(w, a, d, q);
		if (!w) `CHK(q, d)
	endtask : acc
	task automatic seq(input logic [3:0] ld, input ifr_word_t v, input ifr_byte_t ev, input logic ac);
		@(posedge clk) #1;
		{result_load, result_value, flag_event, auto_clear} = {ld, v, ev, ac};
		@(posedge clk) #1;
		{result_load, flag_event, auto_clear} = 13'h0000;
	endtask : seq
	task automatic t_reset;
		for (logic [7:0] a = 8'h21; a < 8'h2A; a++) acc(1'b0, a, 8'h00);
		`CHK(alert, 1'b0)
	endtask : t_reset
	task automatic t_results;
		irq_enable = 8'h3F;
		seq(4'h1, 16'h1234, 8'h01, 1'b0);
		repeat (2) @(posedge clk);
		#1;
		`CHK(alert, 1'b1)
		seq(4'h2, 16'h5678, 8'h02, 1'b0);
		seq(4'h4, 16'h9ABC, 8'h04, 1'b0);
		seq(4'h8, 16'hDEF0, 8'h08, 1'b0);
		acc(1'b0, 8'h22, 8'h34);
		acc(1'b0, 8'h23, 8'h12);
		acc(1'b0, 8'h24, 8'h78);
		acc(1'b0, 8'h25, 8'h56);
		acc(1'b0, 8'h26, 8'hBC);
		acc(1'b0, 8'h27, 8'h9A);
		acc(1'b0, 8'h28, 8'hF0);
		acc(1'b0, 8'h29, 8'h00);
		acc(1'b0, 8'h21, 8'h0F);
	endtask : t_results
	task automatic t_w1c;
		acc(1'b1, 8'h21, 8'hC3);
		seq(4'h0, 16'h0000, 8'h00, 1'b1);
		acc(1'b0, 8'h21, 8'h0C);
		`CHK(alert, 1'b1)
		acc(1'b1, 8'h23, 8'hA5);
		acc(1'b0, 8'h23, 8'hA5);
		acc(1'b1, 8'h21, 8'h3F);
		acc(1'b0, 8'h21, 8'h00);
		`CHK(alert, 1'b0)
	endtask : t_w1c
	task automatic t_auto;
		{irq_enable, clear_policy, proximity_alert_mode_1} = {8'h20, 1'b1, 2'h3};
		seq(4'h0, 16'h0000, 8'h2D, 1'b0);
		seq(4'h0, 16'h0000, 8'h00, 1'b1);
		acc(1'b0, 8'h21, 8'h04);
		`CHK(alert, 1'b0)
	endtask : t_auto
	// a reset in mid-run must wipe results that were loaded or written before it
	task automatic t_rerun;
		seq(4'h4, 16'h5A5A, 8'h00, 1'b0);
		@(posedge clk) #1;
		resetn = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		resetn = 1'b1;
		t_reset();
	endtask : t_rerun
	task end_of_test;
		if (errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		{resetn, irq_enable, clear_policy, auto_clear, result_load, result_value, flag_event} = 39'h0;
		{proximity_alert_mode_1, proximity_alert_mode_2, proximity_alert_mode_3} = 6'h03;
		errors = 0;
		total_checks = 0;
		repeat (6) @(posedge clk);
		#1;
		resetn = 1'b1;
		t_reset();
		t_results();
		t_w1c();
		t_auto();
		t_rerun();
		end_of_test();
	end
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
endmodule : irq_flags_and_result_regs_tb_top
bind ifr_flag_bank ifr_bank_chk u_chk (.*);
